// *** logic/pmic_config_register_bank.sv ***
// configuration register bank: pins, supervisor, power-good delay, load switches
`timescale 1ns/1ns
module pmic_config_register_bank #(
  parameter int unsigned PG_DLY0_CYC = pmic_cfg_pkg::PG_DLY0_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int unsigned PG_DLY1_CYC = pmic_cfg_pkg::PG_DLY1_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int unsigned PG_DLY2_CYC = pmic_cfg_pkg::PG_DLY2_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int unsigned PG_DLY3_CYC = pmic_cfg_pkg::PG_DLY3_MS * pmic_cfg_pkg::CYC_PER_MS,
  parameter int unsigned CYC_PER_S = pmic_cfg_pkg::CLK_HZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port from the management interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic write_unlocked,
  output logic [7:0] rd_data_q,
  // level bits from the enable register, same clock
  input wire logic [2:0] pin_level_bits,
  input wire logic [2:0] switch_en,
  // asynchronous inputs
  input wire logic pg_raw,
  input wire logic gp_pin_one_i,
  input wire logic gp_pin_three_i,
  input wire logic power_fail_ind_n,
  input wire logic push_button_n,
  // general-purpose pins
  output logic gp_pin_one_o_q,
  output logic gp_pin_one_oe_q,
  output logic gp_out_two_o_q,
  output logic gp_out_two_oe_q,
  output logic out2_from_switch_one_supply_q,
  output logic gp_pin_three_o_q,
  output logic gp_pin_three_oe_q,
  output logic core_rails_warm_reset_q,
  // supervisor and power-good
  output logic pg_good_q,
  output logic supervisor_tight_q,
  output logic ov_monitor_en_q,
  output logic pb_reset_q,
  // lockout comparator configuration
  output logic [1:0] lockout_level_q,
  output logic lockout_hysteresis_sel_q,
  // load switches
  output logic [1:0] switch2_current_limit_q,
  output logic [1:0] switch3_current_limit_q,
  output logic [2:0] switch_on_q,
  output logic [2:0] switch_discharge_q
);
  logic [7:0] cfg1_q; // pin and supervisor configuration
  logic [7:0] cfg2_q; // reset routing and current limits
  logic [7:0] cfg3_q; // power-fail and discharge enables
  logic [4:0] sync1_q; // first synchroniser stage, read only by sync2_q
  logic [4:0] sync2_q; // synchronised inputs
  logic pg_s; // power-good from the comparators
  logic pin1_s; // first pin level
  logic pin3_s; // third pin level
  logic pf_n_s; // power-fail indicator, low when tripped
  logic pb_n_s; // push button, low when pressed
  logic [23:0] pg_limit; // selected power-good rise delay in cycles
  logic [31:0] hold_limit; // selected push-button hold in cycles
  logic pin1_fn; // first pin used as input
  logic warm_rst_route; // third pin used as warm reset
  logic out2_level; // level wanted on the second output
  logic [2:0] switch_on_d; // load switch state before registering

  // both hold lengths scale from one per-second count, so they cannot drift apart
  localparam int unsigned HOLD_SHORT_CYC = pmic_cfg_pkg::HOLD_SHORT_S * CYC_PER_S;
  localparam int unsigned HOLD_LONG_CYC = pmic_cfg_pkg::HOLD_LONG_S * CYC_PER_S;

  // write mask for an address; reserved and unmapped bits never store
  function automatic logic [7:0] wmask(input logic [7:0] addr);
    case (addr)
      pmic_cfg_pkg::CFG1_ADDR: wmask = pmic_cfg_pkg::CFG1_WMASK;
      pmic_cfg_pkg::CFG2_ADDR: wmask = pmic_cfg_pkg::CFG2_WMASK;
      pmic_cfg_pkg::CFG3_ADDR: wmask = pmic_cfg_pkg::CFG3_WMASK;
      default: wmask = 8'h00;
    endcase
  endfunction

  // two-stage synchroniser for every pin input
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= pmic_cfg_pkg::SYNC_RST;
      sync2_q <= pmic_cfg_pkg::SYNC_RST;
    end else begin
      sync1_q <= {push_button_n, power_fail_ind_n, gp_pin_three_i, gp_pin_one_i, pg_raw};
      sync2_q <= sync1_q;
    end
  end

  assign pg_s = sync2_q[0];
  assign pin1_s = sync2_q[1];
  assign pin3_s = sync2_q[2];
  assign pf_n_s = sync2_q[3];
  assign pb_n_s = sync2_q[4];

  // first register; only unlocked writes land
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg1_q <= pmic_cfg_pkg::CFG1_RST; // RULE13
    end else if (reg_wr_en && write_unlocked && reg_addr == pmic_cfg_pkg::CFG1_ADDR) begin
      cfg1_q <= reg_wr_data & wmask(reg_addr); // RULE18
    end
  end

  // second register; bits 5:4 are masked so they stay zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg2_q <= pmic_cfg_pkg::CFG2_RST; // RULE14
    end else if (reg_wr_en && write_unlocked && reg_addr == pmic_cfg_pkg::CFG2_ADDR) begin
      cfg2_q <= reg_wr_data & wmask(reg_addr); // RULE14
    end
  end

  // third register; top two bits are masked so they stay zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg3_q <= pmic_cfg_pkg::CFG3_RST; // RULE15
    end else if (reg_wr_en && write_unlocked && reg_addr == pmic_cfg_pkg::CFG3_ADDR) begin
      cfg3_q <= reg_wr_data & wmask(reg_addr); // RULE15
    end
  end

  // read data, one cycle after the strobe; unmapped subaddresses read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        pmic_cfg_pkg::CFG1_ADDR: rd_data_q <= cfg1_q;
        pmic_cfg_pkg::CFG2_ADDR: rd_data_q <= cfg2_q & pmic_cfg_pkg::CFG2_WMASK; // RULE18
        pmic_cfg_pkg::CFG3_ADDR: rd_data_q <= cfg3_q & pmic_cfg_pkg::CFG3_WMASK; // RULE18
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // power-good delay selection from the two-bit code
  always_comb begin
    case (cfg1_q[pmic_cfg_pkg::PG_DLY_LSB +: 2])
      2'h0: pg_limit = 24'(PG_DLY0_CYC); // RULE4
      2'h1: pg_limit = 24'(PG_DLY1_CYC);
      2'h2: pg_limit = 24'(PG_DLY2_CYC);
      2'h3: pg_limit = 24'(PG_DLY3_CYC);
      default: pg_limit = 24'(PG_DLY1_CYC);
    endcase
  end

  // push-button hold time from the top bit
  assign hold_limit = cfg1_q[pmic_cfg_pkg::HOLD_SEL_BIT] ? 32'(HOLD_LONG_CYC)
                                                          : 32'(HOLD_SHORT_CYC); // RULE1

  // rising power-good waits the delay; a fall drops the output the next edge
  level_hold_timer #(.W(24)) pg_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .level(pg_s),
    .limit(pg_limit),
    .done_q(pg_good_q)
  ); // RULE5

  // push-button reset after the button is held the selected time
  level_hold_timer #(.W(32)) hold_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .level(!pb_n_s),
    .limit(hold_limit),
    .done_q(pb_reset_q)
  ); // RULE1

  assign pin1_fn = cfg1_q[pmic_cfg_pkg::PIN1_FN_BIT];
  assign warm_rst_route = cfg2_q[pmic_cfg_pkg::WARM_RST_BIT];
  // in input mode the first pin drives the second output and the level bit is dropped
  assign out2_level = pin1_fn ? pin1_s : pin_level_bits[1]; // RULE3 RULE17

  // general-purpose pin drivers; open-drain pins only ever pull low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gp_pin_one_o_q <= 1'b0;
      gp_pin_one_oe_q <= 1'b0;
      gp_out_two_o_q <= 1'b0;
      gp_out_two_oe_q <= 1'b0;
      out2_from_switch_one_supply_q <= 1'b0;
      gp_pin_three_o_q <= 1'b0;
      gp_pin_three_oe_q <= 1'b0;
    end else begin
      gp_pin_one_o_q <= 1'b0;
      // input mode releases the pin; otherwise a clear level bit pulls low
      gp_pin_one_oe_q <= !pin1_fn && !pin_level_bits[0]; // RULE3 RULE17
      if (cfg1_q[pmic_cfg_pkg::OUT2_TYPE_BIT]) begin
        // push-pull, high level from the first switch input supply
        gp_out_two_o_q <= out2_level; // RULE2
        gp_out_two_oe_q <= 1'b1;
        out2_from_switch_one_supply_q <= 1'b1;
      end else begin
        // open-drain, high level comes from the board pull-up
        gp_out_two_o_q <= 1'b0; // RULE2
        gp_out_two_oe_q <= !out2_level;
        out2_from_switch_one_supply_q <= 1'b0;
      end
      gp_pin_three_o_q <= 1'b0;
      // warm-reset routing turns the driver off and the level bit is dropped
      gp_pin_three_oe_q <= !warm_rst_route && !pin_level_bits[2]; // RULE8 RULE16
    end
  end

  // warm reset to the two core converters while the third pin is held low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_rails_warm_reset_q <= 1'b0;
    end else begin
      core_rails_warm_reset_q <= warm_rst_route && !pin3_s; // RULE8
    end
  end

  // supervisor strictness: clear gives wide limits without overvoltage watch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      supervisor_tight_q <= pmic_cfg_pkg::CFG1_RST[pmic_cfg_pkg::TIGHT_BIT];
      ov_monitor_en_q <= pmic_cfg_pkg::CFG1_RST[pmic_cfg_pkg::TIGHT_BIT];
    end else begin
      supervisor_tight_q <= cfg1_q[pmic_cfg_pkg::TIGHT_BIT]; // RULE6 RULE7
      ov_monitor_en_q <= cfg1_q[pmic_cfg_pkg::TIGHT_BIT]; // RULE6 RULE7
    end
  end

  // static settings handed to the analog side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lockout_level_q <= pmic_cfg_pkg::CFG1_RST[pmic_cfg_pkg::LOCKOUT_LSB +: 2];
      lockout_hysteresis_sel_q <= pmic_cfg_pkg::CFG2_RST[pmic_cfg_pkg::HYST_BIT];
      switch2_current_limit_q <= pmic_cfg_pkg::CFG2_RST[pmic_cfg_pkg::SW2_LIM_LSB +: 2];
      switch3_current_limit_q <= pmic_cfg_pkg::CFG2_RST[pmic_cfg_pkg::SW3_LIM_LSB +: 2];
    end else begin
      lockout_level_q <= cfg1_q[pmic_cfg_pkg::LOCKOUT_LSB +: 2]; // RULE19
      lockout_hysteresis_sel_q <= cfg2_q[pmic_cfg_pkg::HYST_BIT]; // RULE19
      switch2_current_limit_q <= cfg2_q[pmic_cfg_pkg::SW2_LIM_LSB +: 2]; // RULE10
      switch3_current_limit_q <= cfg2_q[pmic_cfg_pkg::SW3_LIM_LSB +: 2]; // RULE9
    end
  end

  // a tripped power-fail indicator overrides the enable where the bit allows
  assign switch_on_d = switch_en & ~(cfg3_q[pmic_cfg_pkg::PF_OFF_LSB +: 3]
                                     & {3{!pf_n_s}}); // RULE11

  // switch state and discharge; discharge and on are never both set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switch_on_q <= 3'h0;
      switch_discharge_q <= 3'h0;
    end else begin
      switch_on_q <= switch_on_d;
      switch_discharge_q <= cfg3_q[pmic_cfg_pkg::DCHRG_LSB +: 3] & ~switch_on_d; // RULE12
    end
  end

  // helper: cycles the synchronised power-good has been high
  logic [23:0] pg_hi_cnt_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pg_hi_cnt_q <= 24'h0;
    end else if (!pg_s) begin
      pg_hi_cnt_q <= 24'h0;
    end else if (pg_hi_cnt_q != 24'hffffff) begin
      pg_hi_cnt_q <= pg_hi_cnt_q + 24'h1;
    end
  end

  // locked writes never change any register
  write_lock_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE18
    (reg_wr_en && !write_unlocked) |=> ($stable(cfg1_q) && $stable(cfg2_q) && $stable(cfg3_q)))
    else $error("register changed by a locked write");

  // reserved bits and unmapped subaddresses read zero on every read
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE18
    reg_rd_en |=> ((rd_data_q & ~wmask($past(reg_addr))) == 8'h00))
    else $error("reserved bits read nonzero");

  // power-good falls one edge after its source, with no delay
  pg_fall_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    !pg_s |=> !pg_good_q)
    else $error("power-good fall delayed");

  // power-good never rises before the selected delay has elapsed
  pg_rise_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    $rose(pg_good_q) |-> (pg_hi_cnt_q >= $past(pg_limit)))
    else $error("power-good rose early");

  // push-pull type drives the second output all the time
  drive_type_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    cfg1_q[pmic_cfg_pkg::OUT2_TYPE_BIT] |=> (gp_out_two_oe_q && out2_from_switch_one_supply_q))
    else $error("push-pull output not driven");

  // input mode never drives the first pin
  pin1_input_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    pin1_fn |=> !gp_pin_one_oe_q)
    else $error("first pin driven in input mode");

  // in input mode a low first pin pulls the second output low
  pin1_ctrl_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE17
    (pin1_fn && !pin1_s) |=> (gp_out_two_oe_q && !gp_out_two_o_q))
    else $error("second output ignores first pin");

  // warm-reset routing releases the pin and forwards a low level
  warm_reset_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    (warm_rst_route && !pin3_s) |=> (core_rails_warm_reset_q && !gp_pin_three_oe_q))
    else $error("warm reset not forwarded");

  // a tripped indicator switches off every switch whose bit is set
  pf_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    !pf_n_s |=> ((switch_on_q & $past(cfg3_q[pmic_cfg_pkg::PF_OFF_LSB +: 3])) == 3'h0))
    else $error("switch stays on during power fail");

  // discharge exactly where enabled and the switch is off
  discharge_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
    1'b1 |=> (switch_discharge_q == ($past(cfg3_q[pmic_cfg_pkg::DCHRG_LSB +: 3]) & ~switch_on_q)))
    else $error("discharge mismatch");

  // a released button drops the reset request at the next edge
  pb_release_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    pb_n_s |=> !pb_reset_q)
    else $error("button reset held after release");

  // without routing the third pin never resets the core converters
  warm_route_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    !warm_rst_route |=> !core_rails_warm_reset_q)
    else $error("warm reset without routing");

  // routing releases the third pin whatever its level bit says
  pin3_release_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
    warm_rst_route |=> !gp_pin_three_oe_q)
    else $error("third pin driven while routed");

  // strictness and overvoltage watch follow the sensitivity bit together
  tight_copy_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    1'b1 |=> (supervisor_tight_q == $past(cfg1_q[pmic_cfg_pkg::TIGHT_BIT])
              && ov_monitor_en_q == supervisor_tight_q))
    else $error("supervisor setting mismatch");

  // main scenarios
  unlocked_write_c: cover property (@(posedge ref_clk) disable iff (rst)
    reg_wr_en && write_unlocked && reg_addr == pmic_cfg_pkg::CFG3_ADDR);
  pg_rise_c: cover property (@(posedge ref_clk) disable iff (rst) $rose(pg_good_q));
  pf_trip_c: cover property (@(posedge ref_clk) disable iff (rst)
    !pf_n_s && cfg3_q[pmic_cfg_pkg::PF_OFF_LSB] && switch_en[0]);
  warm_reset_c: cover property (@(posedge ref_clk) disable iff (rst) core_rails_warm_reset_q);
  pb_hold_c: cover property (@(posedge ref_clk) disable iff (rst) $rose(pb_reset_q));
endmodule

// *** logic/pmic_cfg_pkg.sv ***
// constants for the three byte-wide configuration registers of the power manager
// Function
// RULE1: top bit of first register picks 8s/15s hold
// RULE2: second output open-drain when clear, push-pull when set
// RULE3: function bit turns first pin into control input
// RULE4: delay codes give 10, 20, 50, 150 ms
// RULE5: delay only on rising power-good, falls immediately
// RULE6: sensitivity clear: wide limits, no overvoltage monitoring
// RULE7: sensitivity set (reset): tight limits, overvoltage monitored
// RULE8: routing bit makes third pin a warm-reset input
// RULE9: third switch limit 100/200/500/1000 mA, resets 0
// RULE10: second switch limit in low bits, resets 0
// RULE11: power-fail disable bit turns switch off on fail
// RULE12: discharge bit discharges switch output while off
// RULE13: first register at 0x13, resets to 0x4c
// RULE14: second register at 0x14, resets 0xc0, bits 5:4 reserved
// RULE15: third register at 0x15, resets zero, top bits reserved
// RULE16: routing set ignores third pin level bit
// RULE17: function bit set ignores first/second level bits
// RULE18: writes need unlock; reserved bits read zero
// RULE19: lockout level and hysteresis fed to comparator
package pmic_cfg_pkg;
  // register subaddresses and reset values
  localparam logic [7:0] CFG1_ADDR = 8'h13;
  localparam logic [7:0] CFG2_ADDR = 8'h14;
  localparam logic [7:0] CFG3_ADDR = 8'h15;
  localparam logic [7:0] CFG1_RST = 8'h4c;
  localparam logic [7:0] CFG2_RST = 8'hc0;
  localparam logic [7:0] CFG3_RST = 8'h00;
  // writable bits; reserved bits stay zero
  localparam logic [7:0] CFG1_WMASK = 8'hff;
  localparam logic [7:0] CFG2_WMASK = 8'hcf;
  localparam logic [7:0] CFG3_WMASK = 8'h3f;
  // first register fields
  localparam int HOLD_SEL_BIT = 7;
  localparam int OUT2_TYPE_BIT = 6;
  localparam int PIN1_FN_BIT = 5;
  localparam int PG_DLY_LSB = 3;
  localparam int TIGHT_BIT = 2;
  localparam int LOCKOUT_LSB = 0;
  // second register fields
  localparam int WARM_RST_BIT = 7;
  localparam int HYST_BIT = 6;
  localparam int SW3_LIM_LSB = 2;
  localparam int SW2_LIM_LSB = 0;
  // third register fields
  localparam int PF_OFF_LSB = 3;
  localparam int DCHRG_LSB = 0;
  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PG_DLY0_MS = 10;
  localparam int unsigned PG_DLY1_MS = 20;
  localparam int unsigned PG_DLY2_MS = 50;
  localparam int unsigned PG_DLY3_MS = 150;
  localparam int unsigned HOLD_SHORT_S = 8;
  localparam int unsigned HOLD_LONG_S = 15;
  // synchroniser reset pattern: pg, pin1, pin3, power-fail, button (low to high)
  localparam logic [4:0] SYNC_RST = 5'h1e;
endpackage

// *** logic/level_hold_timer.sv ***
// qualifies a level: done rises after limit cycles high, drops at once
`timescale 1ns/1ns
module level_hold_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // level to qualify and the hold length in cycles
  input wire logic level,
  input wire logic [W-1:0] limit,
  // qualified level
  output logic done_q
);
  logic [W-1:0] cnt_q; // cycles the level has been high

  // count while high; a low level clears both count and output in one edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!level) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (cnt_q >= limit - W'(1)) begin
      done_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end
endmodule

// *** test/host_model.sv ***
// host-side model that drives the register port of the configuration bank
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic ref_clk,
  // register port toward the bank
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  output logic write_unlocked,
  // read data from the bank
  input wire logic [7:0] rd_data_q
);
  // idle values at time zero: no strobe, port locked
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    write_unlocked = 1'b0;
  end

  // one-cycle write; unl says whether the password unlock was completed first
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wr_data = d;
    write_unlocked = unl;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    // released data lines show the inverse so a stale byte can never pass
    reg_wr_data = ~d;
    write_unlocked = 1'b0;
  endtask

  // one-cycle read; data is registered at the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    d = rd_data_q;
    reg_addr = ~a;
  endtask
endmodule

// *** test/tb_pmic_config_register_bank.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
module tb_pmic_config_register_bank;
  logic ref_clk, rst;
  logic [7:0] reg_addr, reg_wr_data, rd_data_q, rv;
  logic reg_wr_en, reg_rd_en, write_unlocked;
  logic [2:0] pin_level_bits, switch_en, switch_on_q, switch_discharge_q;
  logic pg_raw, gp_pin_one_i, gp_pin_three_i, power_fail_ind_n, push_button_n;
  logic gp_pin_one_o_q, gp_pin_one_oe_q, gp_out_two_o_q, gp_out_two_oe_q;
  logic out2_from_switch_one_supply_q, gp_pin_three_o_q, gp_pin_three_oe_q;
  logic core_rails_warm_reset_q, pg_good_q, supervisor_tight_q, ov_monitor_en_q, pb_reset_q;
  logic [1:0] lockout_level_q, switch2_current_limit_q, switch3_current_limit_q;
  logic lockout_hysteresis_sel_q;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  // shortened counts so the run stays short
  int pg_lim[4] = '{10, 20, 50, 150};

  host_model i_host_model (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .write_unlocked(write_unlocked),
    .rd_data_q(rd_data_q));

  pmic_config_register_bank #(.PG_DLY0_CYC(10), .PG_DLY1_CYC(20), .PG_DLY2_CYC(50),
    .PG_DLY3_CYC(150), .CYC_PER_S(5)) i_pmic_config_register_bank (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .write_unlocked(write_unlocked),
    .rd_data_q(rd_data_q), .pin_level_bits(pin_level_bits), .switch_en(switch_en),
    .pg_raw(pg_raw), .gp_pin_one_i(gp_pin_one_i), .gp_pin_three_i(gp_pin_three_i),
    .power_fail_ind_n(power_fail_ind_n), .push_button_n(push_button_n),
    .gp_pin_one_o_q(gp_pin_one_o_q), .gp_pin_one_oe_q(gp_pin_one_oe_q),
    .gp_out_two_o_q(gp_out_two_o_q), .gp_out_two_oe_q(gp_out_two_oe_q),
    .out2_from_switch_one_supply_q(out2_from_switch_one_supply_q),
    .gp_pin_three_o_q(gp_pin_three_o_q), .gp_pin_three_oe_q(gp_pin_three_oe_q),
    .core_rails_warm_reset_q(core_rails_warm_reset_q), .pg_good_q(pg_good_q),
    .supervisor_tight_q(supervisor_tight_q), .ov_monitor_en_q(ov_monitor_en_q),
    .pb_reset_q(pb_reset_q), .lockout_level_q(lockout_level_q),
    .lockout_hysteresis_sel_q(lockout_hysteresis_sel_q),
    .switch2_current_limit_q(switch2_current_limit_q),
    .switch3_current_limit_q(switch3_current_limit_q),
    .switch_on_q(switch_on_q), .switch_discharge_q(switch_discharge_q));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // compare one value, count it, report a mismatch at once
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // let k falling edges pass; async inputs need two sync flops plus one
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // count cycles until power-good (sel 0) or button reset (sel 1) rises, bounded
  task automatic wait_flag(input int sel, output int cnt);
    cnt = 0;
    while (((sel == 0) ? pg_good_q : pb_reset_q) !== 1'b1) begin
      @(negedge ref_clk);
      cnt++;
      if (cnt > 1000) begin
        error_cnt++;
        $display("BAD %0t: wait ran out", $time);
        summarize();
      end
    end
  endtask

  initial begin
    rst = 1'b1;
    pin_level_bits = 3'b111;
    switch_en = 3'b000;
    pg_raw = 1'b0;
    gp_pin_one_i = 1'b1;
    gp_pin_three_i = 1'b1;
    power_fail_ind_n = 1'b1;
    push_button_n = 1'b1;
    tick(16);
    rst = 1'b0;
    tick(4);
    // reset values and the outputs derived from them
    i_host_model.rd(8'h13, rv); check(rv, 8'h4c);
    i_host_model.rd(8'h14, rv); check(rv, 8'hc0);
    i_host_model.rd(8'h15, rv); check(rv, 8'h00);
    check({6'h0, supervisor_tight_q, ov_monitor_en_q}, 8'h03);
    check({4'h0, switch3_current_limit_q, switch2_current_limit_q}, 8'h00);
    check({7'h0, out2_from_switch_one_supply_q}, 8'h01);
    $display("test reset done");
    // locked writes and unmapped places are ignored; reserved bits read zero
    i_host_model.wr(8'h13, 8'hff, 1'b0);
    i_host_model.rd(8'h13, rv); check(rv, 8'h4c);
    i_host_model.wr(8'h16, 8'hff, 1'b1);
    i_host_model.rd(8'h16, rv); check(rv, 8'h00);
    i_host_model.wr(8'h14, 8'hff, 1'b1);
    i_host_model.rd(8'h14, rv); check(rv, 8'hcf);
    i_host_model.wr(8'h15, 8'hff, 1'b1);
    i_host_model.rd(8'h15, rv); check(rv, 8'h3f);
    $display("test access done");
    // every current-limit code on both switches, plus hysteresis copy
    for (int c = 0; c < 4; c++) begin
      i_host_model.wr(8'h14, 8'(c * 4 + (3 - c)) | 8'h80 | 8'(c[0] * 64), 1'b1);
      tick(2);
      check({6'h0, switch3_current_limit_q}, 8'(c));
      check({6'h0, switch2_current_limit_q}, 8'(3 - c));
      check({7'h0, lockout_hysteresis_sel_q}, 8'(c[0]));
    end
    $display("test limits done");
    // sensitivity bit and lockout field
    i_host_model.wr(8'h13, 8'h02, 1'b1);
    tick(2);
    check({6'h0, supervisor_tight_q, ov_monitor_en_q}, 8'h00);
    check({6'h0, lockout_level_q}, 8'h02);
    i_host_model.wr(8'h13, 8'h05, 1'b1);
    tick(2);
    check({6'h0, supervisor_tight_q, ov_monitor_en_q}, 8'h03);
    check({6'h0, lockout_level_q}, 8'h01);
    $display("test supervisor done");
    // power-good rise delay for every code, fall without delay
    for (int c = 0; c < 4; c++) begin
      i_host_model.wr(8'h13, 8'h04 | 8'(c * 8), 1'b1);
      tick(2);
      pg_raw = 1'b1;
      wait_flag(0, n);
      check({7'h0, n >= pg_lim[c] + 1 && n <= pg_lim[c] + 5}, 8'h01);
      pg_raw = 1'b0;
      tick(3);
      check({7'h0, pg_good_q}, 8'h00);
    end
    $display("test power good done");
    // button hold time, short then long
    for (int c = 0; c < 2; c++) begin
      i_host_model.wr(8'h13, 8'h04 | 8'(c * 128), 1'b1);
      tick(2);
      push_button_n = 1'b0;
      wait_flag(1, n);
      check({7'h0, n >= (c ? 76 : 41) && n <= (c ? 80 : 45)}, 8'h01);
      push_button_n = 1'b1;
      tick(4);
      check({7'h0, pb_reset_q}, 8'h00);
    end
    $display("test button done");
    // first pin and second output, open-drain then input-controlled then push-pull
    i_host_model.wr(8'h13, 8'h04, 1'b1);
    pin_level_bits = 3'b000;
    tick(3);
    check({5'h0, out2_from_switch_one_supply_q, gp_pin_one_oe_q, gp_out_two_oe_q}, 8'h03);
    pin_level_bits = 3'b011;
    tick(3);
    check({6'h0, gp_pin_one_oe_q, gp_out_two_oe_q}, 8'h00);
    i_host_model.wr(8'h13, 8'h24, 1'b1);
    pin_level_bits = 3'b000;
    gp_pin_one_i = 1'b0;
    tick(4);
    check({5'h0, gp_pin_one_o_q, gp_pin_one_oe_q, gp_out_two_oe_q}, 8'h01);
    gp_pin_one_i = 1'b1;
    tick(4);
    check({6'h0, gp_pin_one_oe_q, gp_out_two_oe_q}, 8'h00);
    i_host_model.wr(8'h13, 8'h44, 1'b1);
    pin_level_bits = 3'b010;
    tick(3);
    check({5'h0, out2_from_switch_one_supply_q, gp_out_two_oe_q, gp_out_two_o_q}, 8'h07);
    $display("test pins done");
    // third pin: warm-reset input when routed, output otherwise
    i_host_model.wr(8'h14, 8'hc0, 1'b1);
    pin_level_bits = 3'b000;
    gp_pin_three_i = 1'b0;
    tick(4);
    check({6'h0, gp_pin_three_oe_q, core_rails_warm_reset_q}, 8'h01);
    gp_pin_three_i = 1'b1;
    tick(4);
    check({6'h0, gp_pin_three_oe_q, core_rails_warm_reset_q}, 8'h00);
    i_host_model.wr(8'h14, 8'h40, 1'b1);
    gp_pin_three_i = 1'b0;
    tick(4);
    check({5'h0, gp_pin_three_o_q, gp_pin_three_oe_q, core_rails_warm_reset_q}, 8'h02);
    $display("test third pin done");
    // load switches under power fail, with active discharge while off
    i_host_model.wr(8'h15, 8'h2f, 1'b1);
    switch_en = 3'b111;
    power_fail_ind_n = 1'b0;
    tick(4);
    check({5'h0, switch_on_q}, 8'h02);
    check({5'h0, switch_discharge_q}, 8'h05);
    power_fail_ind_n = 1'b1;
    switch_en = 3'b110;
    tick(4);
    check({5'h0, switch_on_q}, 8'h06);
    check({5'h0, switch_discharge_q}, 8'h01);
    i_host_model.wr(8'h15, 8'h02, 1'b1);
    switch_en = 3'b000;
    power_fail_ind_n = 1'b0;
    tick(4);
    check({5'h0, switch_on_q}, 8'h00);
    check({5'h0, switch_discharge_q}, 8'h02);
    $display("test switches done");
    summarize();
  end
endmodule
